/* File: hdl/ipsel_defs.svh */
/*
 * Timing, address and pattern constants for the input-port path of the
 * small 8-bit controller.
 * Assumes inclusion by bare name from the package and modules.
 */
`ifndef IPSEL_DEFS_SVH
`define IPSEL_DEFS_SVH

`define IPSEL_SWITCH_PORT 8'h00
`define IPSEL_BUTTON_PORT 8'h01
`define IPSEL_LED_PORT 8'h01
`define IPSEL_DIR_LED_PORT 8'h02
`define IPSEL_TEST_PATTERN 8'hA5
`define IPSEL_ZERO_BYTE 8'h00
`define IPSEL_REG_SWITCH 4'h0
`define IPSEL_REG_BUTTON 4'h1
`define IPSEL_REG_COUNT 16
`define IPSEL_SETTLE_CYCLES 2'h2

`endif

/* File: hdl/ipsel_pkg.sv */
/*
 * Types shared by the controller core and its port engine.
 * Assumes the constant header is on the include path.
 */
`include "ipsel_defs.svh"

package ipsel_pkg;

    typedef enum logic [4:0] {
        IPSEL_FETCH = 5'h01,
        IPSEL_ISSUE = 5'h02,
        IPSEL_WAIT = 5'h04,
        IPSEL_CAPTURE = 5'h08,
        IPSEL_WRITE = 5'h10
    } ipsel_state_t;

    // One port request: read or write, address source and target
    typedef struct packed {
        logic is_read;
        logic use_reg_addr;
        logic [7:0] imm_addr;
        logic [3:0] addr_reg;
        logic [3:0] data_reg;
    } ipsel_req_t;

    typedef struct packed {
        logic [7:0] port_selector;
        logic read_strobe;
        logic write_strobe;
        logic [7:0] out_data;
    } ipsel_bus_t;

endpackage : ipsel_pkg

/* File: hdl/ipsel_port_engine.sv */
/*
 * Port engine: carries out one input or output access at a time.
 * Assumes the external input multiplexer is a registered stage on the
 * same clock, so data is sampled three edges after the selector settles.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ipsel_defs.svh"

module ipsel_port_engine (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic start_in,
    input wire ipsel_pkg::ipsel_req_t req_in,
    input wire logic [7:0] addr_reg_val_in,
    input wire logic [7:0] data_reg_val_in,
    input wire logic [7:0] in_data_in,
    output logic busy_out,
    output logic done_out,
    output logic wr_en_out,
    output logic [3:0] wr_idx_out,
    output logic [7:0] wr_data_out,
    output ipsel_pkg::ipsel_bus_t bus_out
);

    typedef struct packed {
        ipsel_pkg::ipsel_state_t state;
        ipsel_pkg::ipsel_req_t req;
        logic [1:0] settle;
        logic [7:0] captured;
        ipsel_pkg::ipsel_bus_t bus;
    } ipsel_eng_t;

    ipsel_eng_t eng_reg;
    ipsel_eng_t eng_next;

    always_comb begin
        eng_next = eng_reg;
        eng_next.bus.read_strobe = 1'b0;
        eng_next.bus.write_strobe = 1'b0;
        case (eng_reg.state)
            ipsel_pkg::IPSEL_FETCH: begin
                if (start_in) begin
                    eng_next.req = req_in;
                    eng_next.state = ipsel_pkg::IPSEL_ISSUE;
                end
            end
            ipsel_pkg::IPSEL_ISSUE: begin
                // Register or immediate address onto the selector
                eng_next.bus.port_selector = eng_reg.req.use_reg_addr ?
                    addr_reg_val_in : eng_reg.req.imm_addr;
                eng_next.bus.out_data = data_reg_val_in;
                eng_next.settle = `IPSEL_SETTLE_CYCLES;
                eng_next.state = ipsel_pkg::IPSEL_WAIT;
            end
            ipsel_pkg::IPSEL_WAIT: begin
                // Selector held while the external mux register updates
                if (eng_reg.settle == 2'h1) begin
                    eng_next.state = ipsel_pkg::IPSEL_CAPTURE;
                end
                eng_next.settle = eng_reg.settle - 2'h1;
            end
            ipsel_pkg::IPSEL_CAPTURE: begin
                eng_next.captured = in_data_in;
                eng_next.bus.read_strobe = eng_reg.req.is_read;
                eng_next.bus.write_strobe = !eng_reg.req.is_read;
                eng_next.state = ipsel_pkg::IPSEL_WRITE;
            end
            ipsel_pkg::IPSEL_WRITE: begin
                eng_next.state = ipsel_pkg::IPSEL_FETCH;
            end
            default: begin
                eng_next.state = ipsel_pkg::IPSEL_FETCH;
            end
        endcase
        if (!resetn_in) begin
            eng_next = '0;
            eng_next.state = ipsel_pkg::IPSEL_FETCH;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        eng_reg <= eng_next;
    end

    assign busy_out = (eng_reg.state != ipsel_pkg::IPSEL_FETCH);
    assign done_out = (eng_reg.state == ipsel_pkg::IPSEL_WRITE);
    assign wr_en_out = done_out && eng_reg.req.is_read;
    assign wr_idx_out = eng_reg.req.data_reg;
    assign wr_data_out = eng_reg.captured;
    assign bus_out = eng_reg.bus;

endmodule : ipsel_port_engine

`default_nettype wire

/* File: hdl/ipsel_core.sv */
/*
 * Input-port path of a small 8-bit controller with a fixed test program:
 * the program reads switches and buttons through port reads and writes
 * them back out, or writes a fixed pattern while the mode pin is high.
 * Assumes a registered input multiplexer on sys_clk_in outside the block,
 * decoding selector bits as it needs, and output ports qualified by the
 * write strobe. The mode pin may change at any time and is synchronised
 * here; nothing else crosses a clock.
 */
// Behaviour
// - A port read fetches a byte from any of 256 input ports by selector.
// - A read gets its port from a register or an immediate 00 to FF.
// - A read loads the input byte into one of sixteen registers s0 to sF.
// - The read strobe pulses high on every port read.
// - The program reads no unused port and leaves bits without meaning unmasked.
// - The program loops: switches to LEDs, then buttons to direction LEDs.
// - A fault-isolation mode drives the LEDs with the fixed pattern A5.
// - Each access places the addressed port number on the selector.
`timescale 1ns/10ps
`default_nettype none
`include "ipsel_defs.svh"

module ipsel_core (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic pattern_mode_in,
    input wire logic [7:0] in_data_in,
    output logic [7:0] port_selector_out,
    output logic read_strobe_out,
    output logic write_strobe_out,
    output logic [7:0] out_data_out,
    output logic [7:0] last_switch_out,
    output logic [7:0] last_button_out
);

    typedef enum logic [4:0] {
        IPSEL_STEP_RD_SW = 5'h01,
        IPSEL_STEP_WR_LED = 5'h02,
        IPSEL_STEP_RD_BTN = 5'h04,
        IPSEL_STEP_WR_DIR = 5'h08,
        IPSEL_STEP_LOAD = 5'h10
    } ipsel_step_t;

    typedef struct packed {
        ipsel_step_t step;
        logic started;
        logic [1:0] mode_sync;
        logic [`IPSEL_REG_COUNT-1:0][7:0] gpr;
    } ipsel_core_t;

    ipsel_core_t core_reg;
    ipsel_core_t core_next;

    ipsel_pkg::ipsel_req_t req;
    ipsel_pkg::ipsel_bus_t bus;
    logic eng_busy;
    logic eng_done;
    logic eng_wr_en;
    logic [3:0] eng_wr_idx;
    logic [7:0] eng_wr_data;
    logic start;

    // Mode pin is a board level, so it is synchronised first
    wire logic pattern_mode = core_reg.mode_sync[1];

    always_comb begin
        req = '0;
        case (core_reg.step)
            IPSEL_STEP_RD_SW: begin
                // Only the two mapped ports are ever read
                req.is_read = 1'b1;
                req.imm_addr = `IPSEL_SWITCH_PORT;
                req.data_reg = `IPSEL_REG_SWITCH;
            end
            IPSEL_STEP_WR_LED: begin
                req.imm_addr = `IPSEL_LED_PORT;
                req.data_reg = `IPSEL_REG_SWITCH;
            end
            IPSEL_STEP_RD_BTN: begin
                req.is_read = 1'b1;
                req.imm_addr = `IPSEL_BUTTON_PORT;
                req.data_reg = `IPSEL_REG_BUTTON;
            end
            IPSEL_STEP_WR_DIR: begin
                req.imm_addr = `IPSEL_DIR_LED_PORT;
                req.data_reg = `IPSEL_REG_BUTTON;
            end
            IPSEL_STEP_LOAD: begin
                req.imm_addr = `IPSEL_LED_PORT;
                req.data_reg = `IPSEL_REG_SWITCH;
            end
            default: begin
                req.data_reg = `IPSEL_REG_SWITCH;
            end
        endcase
    end

    assign start = !eng_busy && core_reg.started &&
        (core_reg.step != IPSEL_STEP_LOAD);

    ipsel_port_engine ipsel_port_engine_i (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .start_in(start),
        .req_in(req),
        .addr_reg_val_in(core_reg.gpr[req.addr_reg]),
        .data_reg_val_in(core_reg.gpr[req.data_reg]),
        .in_data_in(in_data_in),
        .busy_out(eng_busy),
        .done_out(eng_done),
        .wr_en_out(eng_wr_en),
        .wr_idx_out(eng_wr_idx),
        .wr_data_out(eng_wr_data),
        .bus_out(bus)
    );

    // Write decode per register; only the engine's target slice updates
    logic [`IPSEL_REG_COUNT-1:0] gpr_wr_sel;
    logic [`IPSEL_REG_COUNT-1:0][7:0] gpr_upd;

    generate
        for (genvar gi = 0; gi < `IPSEL_REG_COUNT; gi++) begin : g_gpr
            assign gpr_wr_sel[gi] = eng_wr_en && (eng_wr_idx == 4'(gi));
            assign gpr_upd[gi] = gpr_wr_sel[gi] ? eng_wr_data :
                core_reg.gpr[gi];
        end
    endgenerate

    always_comb begin
        core_next = core_reg;
        core_next.mode_sync = {core_reg.mode_sync[0], pattern_mode_in};
        core_next.started = 1'b1;
        core_next.gpr = gpr_upd;
        if (core_reg.step == IPSEL_STEP_LOAD) begin
            core_next.gpr[`IPSEL_REG_SWITCH] = `IPSEL_TEST_PATTERN;
            core_next.step = IPSEL_STEP_WR_LED;
        end else if (eng_done) begin
            case (core_reg.step)
                IPSEL_STEP_RD_SW: begin
                    core_next.step = IPSEL_STEP_WR_LED;
                end
                IPSEL_STEP_WR_LED: begin
                    core_next.step = pattern_mode ?
                        IPSEL_STEP_LOAD : IPSEL_STEP_RD_BTN;
                end
                IPSEL_STEP_RD_BTN: begin
                    core_next.step = IPSEL_STEP_WR_DIR;
                end
                IPSEL_STEP_WR_DIR: begin
                    core_next.step = pattern_mode ?
                        IPSEL_STEP_LOAD : IPSEL_STEP_RD_SW;
                end
                default: begin
                    core_next.step = IPSEL_STEP_RD_SW;
                end
            endcase
        end
        if (!resetn_in) begin
            core_next = '0;
            core_next.step = IPSEL_STEP_RD_SW;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        core_reg <= core_next;
    end

    assign port_selector_out = bus.port_selector;
    assign read_strobe_out = bus.read_strobe;
    assign write_strobe_out = bus.write_strobe;
    assign out_data_out = bus.out_data;
    assign last_switch_out = core_reg.gpr[`IPSEL_REG_SWITCH];
    assign last_button_out = core_reg.gpr[`IPSEL_REG_BUTTON];

endmodule : ipsel_core

`default_nettype wire

/* File: test/ipsel_mux_model.sv */
/* Registered input multiplexer model beside the controller.
   Assumes the controller clock and bench-driven switches and buttons. */
`timescale 1ns/10ps
`default_nettype none

module ipsel_mux_model (
    input wire logic clk_in,
    input wire logic [7:0] sel_in,
    input wire logic rd_stb_in,
    input wire logic [7:0] switch_in,
    input wire logic [4:0] btn_in,
    output logic [7:0] data_out,
    output logic [7:0] taken_out
);
    logic [2:0] junk = 3'h5;
    logic [7:0] taken_cnt = 8'h00;

    assign taken_out = taken_cnt;

    // Consumer side, steps once per read as a FIFO would
    always_ff @(posedge clk_in) begin
        if (rd_stb_in) begin
            taken_cnt <= taken_cnt + 8'h01;
        end
    end

    // Selector alone, no strobe, only bit 0 decoded
    always_ff @(posedge clk_in) begin
        junk <= ~junk;
        if (sel_in[0] == 1'b0) begin
            data_out <= switch_in;
        end else begin
            // Spare bits toggle so nothing may rely on them
            data_out <= {junk, btn_in};
        end
    end
endmodule : ipsel_mux_model

`default_nettype wire

/* File: test/ipsel_core_chk.sv */
/* Port checker for the controller input path.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none

module ipsel_core_chk (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic pattern_mode_in,
    input wire logic [7:0] in_data_in,
    input wire logic [7:0] port_selector_out,
    input wire logic read_strobe_out,
    input wire logic write_strobe_out,
    input wire logic [7:0] out_data_out,
    input wire logic [7:0] last_switch_out,
    input wire logic [7:0] last_button_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence rd_s(a);
        read_strobe_out && port_selector_out == a;
    endsequence
    sequence wr_s(a);
        write_strobe_out && port_selector_out == a;
    endsequence

    strobe_pulse_a: assert property (
        read_strobe_out |=> !read_strobe_out)
        else $error("read strobe longer than one cycle");
    strobe_excl_a: assert property (
        !(read_strobe_out && write_strobe_out))
        else $error("read and write strobe together");
    read_port_a: assert property (
        read_strobe_out |-> port_selector_out inside {8'h00, 8'h01})
        else $error("read of an unused port");
    // Selector is set three edges before the strobe is sampled
    sel_hold_a: assert property (
        read_strobe_out |->
        port_selector_out == $past(port_selector_out, 3))
        else $error("selector moved during read");
    switch_load_a: assert property (
        rd_s(8'h00) |=> last_switch_out == $past(in_data_in, 2))
        else $error("s0 not loaded from input");
    button_load_a: assert property (
        rd_s(8'h01) |=> last_button_out == $past(in_data_in, 2))
        else $error("s1 not loaded from input");
    led_write_a: assert property (
        wr_s(8'h01) |-> out_data_out == last_switch_out)
        else $error("led write not s0");
    dir_write_a: assert property (
        wr_s(8'h02) |-> out_data_out == last_button_out)
        else $error("direction write not s1");
    loop_order_a: assert property (
        rd_s(8'h00) |-> ##[1:8] wr_s(8'h01))
        else $error("switch read not followed by led write");
    // Mode pin seen low by the synchroniser sends the loop back to the switch read
    loop_wrap_a: assert property (
        write_strobe_out && port_selector_out == 8'h02 &&
        !$past(pattern_mode_in, 2) |-> ##[1:14] rd_s(8'h00))
        else $error("loop did not restart");
endmodule : ipsel_core_chk

bind ipsel_core ipsel_core_chk ipsel_core_chk_i (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .pattern_mode_in(pattern_mode_in),
    .in_data_in(in_data_in),
    .port_selector_out(port_selector_out),
    .read_strobe_out(read_strobe_out),
    .write_strobe_out(write_strobe_out),
    .out_data_out(out_data_out),
    .last_switch_out(last_switch_out),
    .last_button_out(last_button_out)
);

`default_nettype wire

/* File: test/ipsel_core_test.sv */
/* Self-checking bench for the controller input path.
   Assumes the mux model and the bound checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none

module ipsel_core_test;
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic pattern_mode_in = 1'b0;
    logic [7:0] switches = 8'h00;
    logic [4:0] buttons = 5'h00;
    logic [7:0] in_data, sel, out_data, s0, s1, taken;
    logic rd_stb, wr_stb;
    int miscompares = 0;
    int check_count = 0;

    always #50 sys_clk_in = ~sys_clk_in;

    ipsel_core ipsel_core_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .pattern_mode_in(pattern_mode_in), .in_data_in(in_data),
        .port_selector_out(sel), .read_strobe_out(rd_stb),
        .write_strobe_out(wr_stb), .out_data_out(out_data),
        .last_switch_out(s0), .last_button_out(s1));
    ipsel_mux_model ipsel_mux_model_i (.clk_in(sys_clk_in), .sel_in(sel),
        .rd_stb_in(rd_stb), .switch_in(switches), .btn_in(buttons),
        .data_out(in_data), .taken_out(taken));

    task automatic check8(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check8

    task automatic wait_write(input logic [7:0] p, output logic [7:0] d);
        int n;
        for (n = 0; n < 60; n++) begin
            @(posedge sys_clk_in);
            #1;
            if (wr_stb === 1'b1 && sel === p) break;
        end
        if (n == 60) begin
            miscompares++;
            $display("CHECK FAILED write strobe expected 1 seen 0");
        end
        d = out_data;
    endtask : wait_write

    task automatic test_reset;
        check8("selector", 8'h00, sel);
        check8("strobes", 8'h00, {6'h00, rd_stb, wr_stb});
        $display("test_reset done");
    endtask : test_reset

    task automatic test_switches;
        logic [7:0] vals [4] = '{8'h00, 8'hFF, 8'h5A, 8'h81};
        logic [7:0] d;
        logic [7:0] t0;
        foreach (vals[i]) begin
            @(negedge sys_clk_in);
            switches = vals[i];
            wait_write(8'h01, d);
            t0 = taken;
            wait_write(8'h01, d);
            // One loop holds exactly one switch read and one button read
            check8("reads per loop", t0 + 8'h02, taken);
            check8("led data", vals[i], d);
            check8("s0", vals[i], s0);
        end
        $display("test_switches done");
    endtask : test_switches

    task automatic test_buttons;
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            @(negedge sys_clk_in);
            buttons = 5'h01 << i;
            repeat (2) wait_write(8'h02, d);
            check8("dir data", {3'h0, 5'h01 << i}, {3'h0, d[4:0]});
            check8("s1", {3'h0, 5'h01 << i}, {3'h0, s1[4:0]});
        end
        $display("test_buttons done");
    endtask : test_buttons

    task automatic test_pattern;
        logic [7:0] d;
        logic [7:0] seen;
        seen = 8'h00;
        @(negedge sys_clk_in);
        switches = 8'h3C;
        pattern_mode_in = 1'b1;
        for (int k = 0; k < 6; k++) begin
            wait_write(8'h01, d);
            if (d === 8'hA5) seen = 8'hA5;
        end
        check8("pattern", 8'hA5, seen);
        @(negedge sys_clk_in);
        pattern_mode_in = 1'b0;
        repeat (4) wait_write(8'h01, d);
        check8("led after pattern", 8'h3C, d);
        $display("test_pattern done");
    endtask : test_pattern

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20) @(negedge sys_clk_in);
        test_reset;
        resetn_in = 1'b1;
        test_switches;
        test_buttons;
        test_pattern;
        conclude;
    end

    // Whole run needs about 600 cycles
    initial begin
        #(100 * 4000);
        miscompares++;
        conclude;
    end
endmodule : ipsel_core_test

`default_nettype wire
